// file: bench/exception_fp_context_state_tb_top.sv
// Self-checking bench for the exception and floating-point context state block.
`timescale 1ns/100ps
`include "exc_fp_cfg.svh"
module exception_fp_context_state_tb_top;
   import exc_fp_pkg::*;
   logic        core_clk = 1'b0, arst_n = 1'b0, main_ext_present = 1'b1, fp_ext_present = 1'b1;
   logic        nonsecure_priority_halving = 1'b0, nonsecure_fault_routing = 1'b0, cur_secure = 1'b1;
   logic        mm_req = 1'b0, mm_write = 1'b0, mm_priv = 1'b0, mm_secure = 1'b0, mm_debug = 1'b0;
   logic [1:0]  mm_size = `SIZE_WORD;
   logic [31:0] mm_addr = 32'h0, mm_wdata = 32'h0, sr_wdata = 32'h0, ret_payload = 32'h0, fret_payload = 32'h0;
   logic [31:0] lazy_frame_addr = 32'h0, mm_rdata, sr_rdata, exception_return_payload, function_return_payload, r;
   logic        sr_req = 1'b0, sr_write = 1'b0, sr_sel = 1'b0, sr_priv = 1'b0, sr_secure = 1'b0;
   logic        entry_valid = 1'b0, ret_valid = 1'b0, raw_prio_nonneg = 1'b0, fcall_valid = 1'b0, fret_valid = 1'b0;
   logic        lazy_set = 1'b0, lazy_clear = 1'b0, lazy_bank_secure = 1'b0, issue = 1'b0, issue_fp = 1'b0;
   logic        mm_ack, mm_fault, sr_ack, insn_valid, insn_is_fp, fp_context_active_flag, invalid_state_fault;
   logic        fpca_set, ret_done, clear_fp_regs, fret_match, boost_active;
   logic [7:0]  cond_block_view, continuation_view;
   logic [8:0]  boost_prio;
   logic [8:0]  bexp [4] = '{`PRIO_ZERO, `PRIO_HALF, `PRIO_NEG1, `PRIO_NEG1};
   frame_info_t entry_info = '0, ret_info, fi;
   logic [33:0] notes [$];
   logic [33:0] note;
   logic [32:0] got;
   int          n_fail = 0, checked = 0;

   exception_fp_context_state DUT (.*);
   fp_pipeline_model partner (.*);

   always #5 core_clk = ~core_clk;

   task automatic chk(input logic [32:0] got_v, exp_v);
      checked++;
      if (got_v !== exp_v) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got_v, exp_v);
      end
   endtask : chk

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // Note layout: compare-data flag, expected fault, expected data. Writes compare the fault only.
   task automatic mm(input logic w, input logic [31:0] a, d, input logic p, s);
      @(posedge core_clk);
      mm_req <= 1'b1;
      mm_write <= w;
      mm_addr <= a;
      mm_wdata <= w ? d : ~d;
      mm_priv <= p;
      mm_secure <= s;
      notes.push_back({!w, !p, w ? 32'h0 : d});
      @(posedge core_clk);
      mm_req <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask : mm

   task automatic sr(input logic w, sel, input logic [31:0] d, input logic p, s);
      @(posedge core_clk);
      sr_req <= 1'b1;
      sr_write <= w;
      sr_sel <= sel;
      sr_wdata <= w ? d : ~d;
      sr_priv <= p;
      sr_secure <= s;
      notes.push_back({!w, 1'b0, w ? 32'h0 : d});
      @(posedge core_clk);
      sr_req <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask : sr

   task automatic ret(input logic es, nn, cl);
      logic [31:0] p;
      p = {`EXC_PREFIX, `EXC_RES1, 5'($urandom), 1'b0, es};
      ret_payload <= p;
      raw_prio_nonneg <= nn;
      ret_valid <= 1'b1;
      @(posedge core_clk);
      ret_valid <= 1'b0;
      #1 chk({ret_done, ret_info, clear_fp_regs}, {1'b1, p[6:5], p[4] | !fp_ext_present, p[3:2], p[0], cl});
   endtask : ret

   always @(posedge core_clk) begin
      if (mm_ack | sr_ack) begin
         note = notes.size() > 0 ? notes.pop_front() : 34'h3_FFFF_FFFF;
         got = mm_ack ? {mm_fault, mm_rdata} : {1'b0, sr_rdata};
         if (!note[33])
            got[31:0] = note[31:0];
         chk(got, note[32:0]);
      end
   end

   initial begin
      #20000;
      n_fail++;
      finish_test();
   end

   initial begin
      r = $urandom(65);
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      issue <= 1'b1;
      mm(0, `CCR_ADDR, 32'hC000_0000, 1, 1);
      mm(0, `CAR_ADDR, 32'h0, 1, 1);
      sr(0, `SR_EXECUTION_STATE_WORD, 32'h0, 1, 1);
      chk(invalid_state_fault, 1'b1);
      r = $urandom | 32'h0100_0000;
      sr(1, `SR_EXECUTION_STATE_WORD, r, 1, 1);
      sr(1, `SR_EXECUTION_STATE_WORD, 32'h0, 0, 1);
      sr(0, `SR_EXECUTION_STATE_WORD, 32'h0, 0, 1);
      sr(0, `SR_EXECUTION_STATE_WORD, r & 32'h0700_FC00, 1, 1);
      chk(cond_block_view, {r[15:10], r[26:25]});
      chk(continuation_view, {r[26:25], r[15:10]});
      chk(invalid_state_fault, 1'b0);
      sr(1, `SR_EXECUTION_STATE_WORD, 32'h0, 1, 1);
      chk(invalid_state_fault, 1'b1);
      sr(1, `SR_EXECUTION_STATE_WORD, r, 1, 1);
      main_ext_present <= 1'b0;
      sr(0, `SR_EXECUTION_STATE_WORD, r & 32'h0100_0000, 1, 1);
      main_ext_present <= 1'b1;
      issue_fp <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk(fp_context_active_flag, 1'b1);
      issue <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         fi = frame_info_t'(6'($urandom));
         fp_ext_present <= i < 8;
         entry_info <= fi;
         entry_valid <= 1'b1;
         @(posedge core_clk);
         entry_valid <= 1'b0;
         #1 chk(exception_return_payload, {`EXC_PREFIX, `EXC_RES1, fi[5:4], fi[3] | (i == 8), fi[2:1], 1'b0, fi[0]});
      end
      mm(0, `CCR_ADDR, 32'h0, 1, 1);
      ret(1'b0, 1'b0, 1'b0);
      fp_ext_present <= 1'b1;
      fcall_valid <= 1'b1;
      @(posedge core_clk);
      fcall_valid <= 1'b0;
      #1 chk(function_return_payload, {`FNC_PREFIX, `FNC_ONES, 1'b1});
      for (int i = 0; i < 3; i++) begin
         fret_payload <= {i == 2 ? `EXC_PREFIX : `FNC_PREFIX, `FNC_ONES, i[0]};
         fret_valid <= 1'b1;
         #10 chk(fret_match, i != 2);
      end
      fret_valid <= 1'b0;
      mm(1, `CCR_ADDR, 32'hFFFF_FFFE, 1, 0);
      mm(0, `CCR_ADDR, 32'hD000_0000, 1, 0);
      mm(0, `CCR_NS_ADDR, 32'hD000_0000, 1, 1);
      mm(0, `CCR_NS_ADDR, 32'h0, 1, 0);
      mm(1, `CCR_ADDR, 32'h7800_0000, 1, 1);
      mm(1, `CCR_ADDR, 32'h8000_0000, 1, 0);
      mm(0, `CCR_ADDR, 32'hD000_0000, 1, 0);
      mm_size <= 2'h0;
      mm(1, `CCR_ADDR, 32'h0, 1, 1);
      mm_size <= `SIZE_WORD;
      mm(0, `CCR_ADDR, 32'h7800_0000, 1, 1);
      mm(0, `CCR_ADDR, 32'h0, 0, 1);
      mm(0, 32'hE000_EF30, 32'h0, 1, 1);
      r = $urandom;
      mm(1, `CAR_ADDR, r, 1, 1);
      mm(0, `CAR_ADDR, r & 32'hFFFF_FFF8, 1, 1);
      mm(0, `CAR_ADDR, 32'h0, 1, 0);
      mm_debug <= 1'b1;
      mm(0, `CAR_NS_ADDR, 32'h0, 1, 1);
      mm_debug <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         nonsecure_priority_halving <= i == 1;
         nonsecure_fault_routing <= i == 2;
         sr(1, `SR_FMASK, 32'h1, 1, i == 3);
         sr(0, `SR_FMASK, 32'h1, 1, i == 3);
         chk({boost_active, boost_prio}, {1'b1, bexp[i]});
         ret(i == 3, i != 1, 1'b1);
         @(posedge core_clk);
         #1 chk(boost_active, i == 1);
         sr(1, `SR_FMASK, 32'h0, 1, i == 3);
      end
      r = $urandom;
      lazy_bank_secure <= 1'b1;
      lazy_frame_addr <= r;
      lazy_set <= 1'b1;
      @(posedge core_clk);
      lazy_set <= 1'b0;
      mm(0, `CCR_ADDR, 32'h7800_0001, 1, 1);
      mm(0, `CCR_ADDR, 32'hD000_0000, 1, 0);
      mm(0, `CAR_ADDR, r & 32'hFFFF_FFF8, 1, 1);
      ret(1'b0, 1'b1, 1'b0);
      lazy_clear <= 1'b1;
      @(posedge core_clk);
      lazy_clear <= 1'b0;
      mm(0, `CCR_ADDR, 32'h7800_0000, 1, 1);
      finish_test();
   end
endmodule : exception_fp_context_state_tb_top

// file: bench/fp_pipeline_model.sv
// Pipeline model that issues instructions and holds the context-active control flag.
`timescale 1ns/100ps
module fp_pipeline_model (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic arst_n,
   // Commands from the bench.
   input  wire logic issue,
   input  wire logic issue_fp,
   // Block side.
   input  wire logic fpca_set,
   output logic      insn_valid,
   output logic      insn_is_fp,
   output logic      fp_context_active_flag
);
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         insn_valid <= 1'b0;
         insn_is_fp <= 1'b0;
      end else begin
         insn_valid <= issue;
         insn_is_fp <= issue & issue_fp;
      end
   end

   // The flag is only ever set here, so a missing set pulse shows as a stuck zero.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         fp_context_active_flag <= 1'b0;
      else if (fpca_set)
         fp_context_active_flag <= 1'b1;
   end
endmodule : fp_pipeline_model

// file: rtl/exc_fp_cfg.svh
// Constants for the exception and floating-point context state block.
`ifndef EXC_FP_CFG_SVH
`define EXC_FP_CFG_SVH
`define CCR_ADDR      32'hE000EF34
`define CAR_ADDR      32'hE000EF38
`define CCR_NS_ADDR   32'hE002EF34
`define CAR_NS_ADDR   32'hE002EF38
`define SIZE_WORD     2'h2
`define SR_EXECUTION_STATE_WORD       1'h0
`define SR_FMASK      1'h1
`define B_AUTO_SAVE_ENABLE       31
`define B_LAZY_SAVE_ENABLE       30
`define B_LOCK        29
`define B_CLR         28
`define B_CLRLOCK     27
`define B_LAZY_SAVE_ACTIVE      0
`define B_T           24
`define B_IT_HI       26
`define B_IT_HI_LO    25
`define B_IT_LO       15
`define B_IT_LO_LO    10
`define B_FM          0
`define CAR_LSB       3
`define P_SSTACK      6
`define P_CALLEE_STACKING_DEFAULT        5
`define P_FRAME_KIND       4
`define P_MODE        3
`define P_STACK_POINTER_SELECT       2
`define P_ES          0
`define EXC_PREFIX    8'hFF
`define EXC_RES1      17'h1FFFF
`define FNC_PREFIX    8'hFE
`define FNC_ONES      23'h7FFFFF
`define PRIO_ZERO     9'h000
`define PRIO_HALF     9'h080
`define PRIO_NEG1     9'h1FF
`define AUTO_SAVE_ENABLE_RST     1'h1
`define LAZY_SAVE_ENABLE_RST     1'h1
`define WORD_ZERO     32'h0000_0000
`endif

// file: rtl/exc_fp_pkg.sv
// Types shared by the exception and floating-point context state block.
package exc_fp_pkg;
   typedef struct packed {
      logic secure_stack;
      logic callee_stacking_default;
      logic frame_kind;
      logic thread_mode;
      logic stack_pointer_select;
      logic exception_domain_secure;
   } frame_info_t;
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_CCR,
      SEL_CCR_NS,
      SEL_CAR,
      SEL_CAR_NS
   } reg_sel_t;
endpackage : exc_fp_pkg

// file: rtl/exception_fp_context_state.sv
// Execution state, return payloads, priority boost and floating-point context control.
`timescale 1ns/100ps
`include "exc_fp_cfg.svh"
// Overview of operation
// - State bit zero makes every executed instruction raise an invalid-state usage fault.
// - Condition view is bits 15:10 then 26:25; continuation view the reverse.
// - Condition field clears on reset, reads zero and ignores writes without main extension.
// - Exception payload has prefix all ones, bits 23:7 ones, bit 1 zero.
// - Payload bit 6 selects the secure stack for restoring the frame.
// - Payload bit 5 zero means callee registers were already stacked.
// - Payload bit 4 zero is extended frame; reads one without floating point.
// - Payload bit 3 records thread mode as one, handler mode as zero.
// - Payload bit 2 records process stack pointer as one, main as zero.
// - Payload bit 0 records the security domain the exception was taken to.
// - Non-secure mask without routing boosts to 0, or 0x80 with halving.
// - Secure mask, or routed non-secure mask, boosts priority to minus one.
// - Return from non-negative raw priority clears the mask of the payload domain.
// - Function payload has prefix 0xFE, bits 23:1 ones, bit 0 calling state.
// - Generated function payload bit 0 is one; matching ignores that bit.
// - Context address holds bits 31:3; non-secure alias is zero for others.
// - Control register banked per bit, privileged word access only; unprivileged access bus faults, other sizes are ignored.
// - Auto-save enable makes floating-point instructions set the context-active flag.
// - Lazy-save enable resets to one; non-secure writes ignored while locked.
// - Lazy-save lock resets zero, reads zero from the non-secure view and ignores non-secure writes.
// - Clear-on-return wipes S0 to S15 and status when context active, not lazy.
// - Clear-on-return lock makes the clear-on-return bit read-only from the non-secure view; secure only, resets zero.
// - Lazy-active bit is banked per security state and resets to zero.
module exception_fp_context_state
   import exc_fp_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Configuration.
   input  wire logic        main_ext_present,
   input  wire logic        fp_ext_present,
   input  wire logic        nonsecure_priority_halving,
   input  wire logic        nonsecure_fault_routing,
   // Memory-mapped register access.
   input  wire logic        mm_req,
   input  wire logic        mm_write,
   input  wire logic [31:0] mm_addr,
   input  wire logic [1:0]  mm_size,
   input  wire logic [31:0] mm_wdata,
   input  wire logic        mm_priv,
   input  wire logic        mm_secure,
   input  wire logic        mm_debug,
   output logic             mm_ack,
   output logic             mm_fault,
   output logic [31:0]      mm_rdata,
   // Special-purpose register access.
   input  wire logic        sr_req,
   input  wire logic        sr_write,
   input  wire logic        sr_sel,
   input  wire logic        sr_priv,
   input  wire logic        sr_secure,
   input  wire logic [31:0] sr_wdata,
   output logic             sr_ack,
   output logic [31:0]      sr_rdata,
   // Pipeline.
   input  wire logic        insn_valid,
   input  wire logic        insn_is_fp,
   input  wire logic        cur_secure,
   input  wire logic        fp_context_active_flag,
   output logic             invalid_state_fault,
   output logic             fpca_set,
   output logic [7:0]       cond_block_view,
   output logic [7:0]       continuation_view,
   // Exception entry and return.
   input  wire logic        entry_valid,
   input  wire frame_info_t entry_info,
   output logic [31:0]      exception_return_payload,
   input  wire logic        ret_valid,
   input  wire logic [31:0] ret_payload,
   input  wire logic        raw_prio_nonneg,
   output logic             ret_done,
   output frame_info_t      ret_info,
   output logic             clear_fp_regs,
   // Secure function calls.
   input  wire logic        fcall_valid,
   output logic [31:0]      function_return_payload,
   input  wire logic        fret_valid,
   input  wire logic [31:0] fret_payload,
   output logic             fret_match,
   // Lazy preservation.
   input  wire logic        lazy_set,
   input  wire logic        lazy_clear,
   input  wire logic        lazy_bank_secure,
   input  wire logic [31:0] lazy_frame_addr,
   // Priority boost.
   output logic             boost_active,
   output logic [8:0]       boost_prio
);

   logic        t_bit;
   logic [1:0]  it_hi;
   logic [5:0]  it_lo;
   logic [1:0]  fm;
   logic [1:0]  auto_save_enable;
   logic [1:0]  lazy_save_active;
   logic        lazy_save_enable;
   logic        lazy_save_lock;
   logic        clear_on_return;
   logic        clear_on_return_lock;
   logic [28:0] car [2];
   reg_sel_t    sel;
   logic        acc_ok;
   logic        view_sec;
   logic        mm_wr;
   logic        sr_wr;
   logic        next_boost_active;
   logic [8:0]  next_boost_prio;

   // Builds the control register word as seen from one security view.
   function automatic logic [31:0] ccr_word(input logic sec);
      logic [31:0] w;
      w                = `WORD_ZERO;
      w[`B_AUTO_SAVE_ENABLE]      = auto_save_enable[sec];
      w[`B_LAZY_SAVE_ENABLE]      = lazy_save_enable;
      w[`B_LOCK]       = sec & lazy_save_lock;
      w[`B_CLR]        = clear_on_return;
      w[`B_CLRLOCK]    = sec & clear_on_return_lock;
      w[`B_LAZY_SAVE_ACTIVE]     = lazy_save_active[sec];
      return w;
   endfunction : ccr_word

   // Reports whether a payload carries the function-return pattern, bit 0 ignored.
   function automatic logic is_fnc(input logic [31:0] p);
      return p[31:1] == {`FNC_PREFIX, `FNC_ONES};
   endfunction : is_fnc

   // Non-secure alias addresses are hidden from non-secure code and the debugger.
   always_comb begin
      sel = SEL_NONE;
      if (fp_ext_present) begin
         if (mm_addr == `CCR_ADDR)
            sel = SEL_CCR;
         else if (mm_addr == `CAR_ADDR)
            sel = SEL_CAR;
         else if (mm_addr == `CCR_NS_ADDR && mm_secure && !mm_debug)
            sel = SEL_CCR_NS;
         else if (mm_addr == `CAR_NS_ADDR && mm_secure && !mm_debug)
            sel = SEL_CAR_NS;
      end
   end

   assign acc_ok   = mm_priv && mm_size == `SIZE_WORD;
   assign view_sec = mm_secure && (sel == SEL_CCR || sel == SEL_CAR);
   assign mm_wr    = mm_req && mm_write && acc_ok;
   assign sr_wr    = sr_req && sr_write && sr_priv;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mm_ack   <= 1'b0;
         mm_fault <= 1'b0;
         mm_rdata <= `WORD_ZERO;
      end else begin
         mm_ack   <= mm_req;
         mm_fault <= mm_req && !mm_priv;
         mm_rdata <= `WORD_ZERO;
         if (mm_req && !mm_write && acc_ok) begin
            unique case (sel)
               SEL_CCR:    mm_rdata <= ccr_word(mm_secure);
               SEL_CCR_NS: mm_rdata <= ccr_word(1'b0);
               SEL_CAR:    mm_rdata <= {car[mm_secure], 3'h0};
               SEL_CAR_NS: mm_rdata <= {car[0], 3'h0};
               SEL_NONE:   mm_rdata <= `WORD_ZERO;
            endcase
         end
      end
   end

   // Unbanked enables and their secure-only locks.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lazy_save_enable     <= `LAZY_SAVE_ENABLE_RST;
         lazy_save_lock    <= 1'b0;
         clear_on_return  <= 1'b0;
         clear_on_return_lock <= 1'b0;
      end else if (mm_wr && (sel == SEL_CCR || sel == SEL_CCR_NS)) begin
         if (view_sec || !lazy_save_lock)
            lazy_save_enable <= mm_wdata[`B_LAZY_SAVE_ENABLE];
         if (view_sec)
            lazy_save_lock <= mm_wdata[`B_LOCK];
         if (view_sec || !clear_on_return_lock)
            clear_on_return <= mm_wdata[`B_CLR];
         if (view_sec)
            clear_on_return_lock <= mm_wdata[`B_CLRLOCK];
      end
   end

   // Banked auto-save enable and lazy-active bits; a hardware set beats any clear.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         auto_save_enable  <= {`AUTO_SAVE_ENABLE_RST, `AUTO_SAVE_ENABLE_RST};
         lazy_save_active <= 2'h0;
      end else begin
         if (mm_wr && (sel == SEL_CCR || sel == SEL_CCR_NS)) begin
            auto_save_enable[view_sec]  <= mm_wdata[`B_AUTO_SAVE_ENABLE];
            lazy_save_active[view_sec] <= mm_wdata[`B_LAZY_SAVE_ACTIVE];
         end
         if (lazy_clear)
            lazy_save_active[lazy_bank_secure] <= 1'b0;
         if (lazy_set)
            lazy_save_active[lazy_bank_secure] <= 1'b1;
      end
   end

   // Banked context address; reset value is defined for determinism.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         car[0] <= 29'h0;
         car[1] <= 29'h0;
      end else if (lazy_set) begin
         car[lazy_bank_secure] <= lazy_frame_addr[31:`CAR_LSB];
      end else if (mm_wr && sel == SEL_CAR) begin
         car[mm_secure] <= mm_wdata[31:`CAR_LSB];
      end else if (mm_wr && sel == SEL_CAR_NS) begin
         car[0] <= mm_wdata[31:`CAR_LSB];
      end
   end

   // Execution state word.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         t_bit <= 1'b0;
         it_hi <= 2'h0;
         it_lo <= 6'h0;
      end else if (sr_wr && sr_sel == `SR_EXECUTION_STATE_WORD) begin
         t_bit <= sr_wdata[`B_T];
         if (main_ext_present) begin
            it_hi <= sr_wdata[`B_IT_HI:`B_IT_HI_LO];
            it_lo <= sr_wdata[`B_IT_LO:`B_IT_LO_LO];
         end
      end
   end

   // Banked fault mask; the return clear is applied before a same-cycle software set.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fm <= 2'h0;
      end else begin
         if (ret_valid && raw_prio_nonneg)
            fm[ret_payload[`P_ES]] <= 1'b0;
         if (sr_wr && sr_sel == `SR_FMASK && main_ext_present)
            fm[sr_secure] <= sr_wdata[`B_FM];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sr_ack   <= 1'b0;
         sr_rdata <= `WORD_ZERO;
      end else begin
         sr_ack   <= sr_req;
         sr_rdata <= `WORD_ZERO;
         if (sr_req && !sr_write && sr_priv) begin
            if (sr_sel == `SR_EXECUTION_STATE_WORD) begin
               sr_rdata[`B_T]                    <= t_bit;
               sr_rdata[`B_IT_HI:`B_IT_HI_LO]    <= main_ext_present ? it_hi : 2'h0;
               sr_rdata[`B_IT_LO:`B_IT_LO_LO]    <= main_ext_present ? it_lo : 6'h0;
            end else begin
               sr_rdata[`B_FM] <= main_ext_present & fm[sr_secure];
            end
         end
      end
   end

   assign cond_block_view     = main_ext_present ? {it_lo, it_hi} : 8'h00;
   assign continuation_view   = main_ext_present ? {it_hi, it_lo} : 8'h00;
   assign invalid_state_fault = insn_valid && !t_bit;
   assign fpca_set            = insn_valid && t_bit && insn_is_fp && fp_ext_present
                                && auto_save_enable[cur_secure];
   assign fret_match          = fret_valid && is_fnc(fret_payload);

   always_comb begin
      next_boost_active = 1'b1;
      next_boost_prio   = `PRIO_NEG1;
      if (fm[1] || (nonsecure_fault_routing && fm[0])) begin
         next_boost_prio = `PRIO_NEG1;
      end else if (fm[0]) begin
         next_boost_prio = nonsecure_priority_halving ? `PRIO_HALF : `PRIO_ZERO;
      end else begin
         next_boost_active = 1'b0;
         next_boost_prio   = `PRIO_ZERO;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         boost_active <= 1'b0;
         boost_prio   <= `PRIO_ZERO;
      end else begin
         boost_active <= next_boost_active;
         boost_prio   <= next_boost_prio;
      end
   end

   // Payload generation.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         exception_return_payload <= `WORD_ZERO;
         function_return_payload  <= `WORD_ZERO;
      end else begin
         if (entry_valid) begin
            exception_return_payload <= {`EXC_PREFIX, `EXC_RES1,
                                         entry_info.secure_stack,
                                         entry_info.callee_stacking_default,
                                         entry_info.frame_kind || !fp_ext_present,
                                         entry_info.thread_mode,
                                         entry_info.stack_pointer_select,
                                         1'b0,
                                         entry_info.exception_domain_secure};
         end
         if (fcall_valid)
            function_return_payload <= {`FNC_PREFIX, `FNC_ONES, 1'b1};
      end
   end

   // Return decoding and clear-on-return.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ret_done      <= 1'b0;
         ret_info      <= '0;
         clear_fp_regs <= 1'b0;
      end else begin
         ret_done      <= ret_valid;
         clear_fp_regs <= ret_valid && fp_ext_present && clear_on_return
                          && fp_context_active_flag && !lazy_save_active[1];
         if (ret_valid) begin
            ret_info.secure_stack            <= ret_payload[`P_SSTACK];
            ret_info.callee_stacking_default <= ret_payload[`P_CALLEE_STACKING_DEFAULT];
            ret_info.frame_kind              <= ret_payload[`P_FRAME_KIND] || !fp_ext_present;
            ret_info.thread_mode             <= ret_payload[`P_MODE];
            ret_info.stack_pointer_select    <= ret_payload[`P_STACK_POINTER_SELECT];
            ret_info.exception_domain_secure <= ret_payload[`P_ES];
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence execution_state_word_t_clear_s;
      sr_wr && sr_sel == `SR_EXECUTION_STATE_WORD && !sr_wdata[`B_T];
   endsequence
   sequence ns_ccr_write_s;
      mm_wr && !view_sec && (sel == SEL_CCR || sel == SEL_CCR_NS);
   endsequence
   sequence fm_s_set_s;
      sr_wr && sr_sel == `SR_FMASK && sr_secure && sr_wdata[`B_FM] && main_ext_present;
   endsequence

   state_fault_a: assert property (execution_state_word_t_clear_s ##1 (!sr_wr && insn_valid) |-> invalid_state_fault)
      else $error("cleared state bit did not fault execution");
   view_order_a: assert property (continuation_view == {cond_block_view[1:0], cond_block_view[7:2]})
      else $error("condition and continuation views disagree");
   it_absent_a: assert property (!main_ext_present |-> cond_block_view == 8'h00)
      else $error("condition field visible without main extension");
   exc_prefix_a: assert property (entry_valid |=> exception_return_payload[31:7] == {`EXC_PREFIX, `EXC_RES1}
                                  && !exception_return_payload[1])
      else $error("exception payload fixed bits wrong");
   exc_fields_a: assert property (entry_valid |=> exception_return_payload[`P_STACK_POINTER_SELECT]
                                  == $past(entry_info.stack_pointer_select)
                                  && exception_return_payload[`P_ES] == $past(entry_info.exception_domain_secure))
      else $error("exception payload fields do not follow entry");
   frame_kind_one_a: assert property (ret_valid && !fp_ext_present |=> ret_info.frame_kind)
      else $error("frame kind not one without floating point");
   secure_boost_a: assert property (fm_s_set_s |=> ##1 boost_active && boost_prio == `PRIO_NEG1)
      else $error("secure mask did not boost to minus one");
   ns_boost_a: assert property (fm == 2'h1 && !nonsecure_fault_routing && nonsecure_priority_halving
                                |=> boost_prio == `PRIO_HALF)
      else $error("halved non-secure boost wrong");
   mask_clear_a: assert property (ret_valid && raw_prio_nonneg && ret_payload[`P_ES] && !sr_wr
                                  |=> !fm[1])
      else $error("return did not clear secure fault mask");
   fnc_payload_a: assert property (fcall_valid |=> function_return_payload == {`FNC_PREFIX, `FNC_ONES, 1'b1})
      else $error("function payload wrong");
   lazy_save_enable_lock_a: assert property (ns_ccr_write_s and (lazy_save_lock ##0 1'b1) |=> $stable(lazy_save_enable))
      else $error("locked lazy-save enable changed from non-secure");
   clr_cause_a: assert property (clear_fp_regs |-> $past(ret_valid) && $past(fp_context_active_flag)
                                 && !$past(lazy_save_active[1]))
      else $error("floating-point clear without its cause");
   unpriv_fault_a: assert property (mm_req && !mm_priv |=> mm_fault && mm_ack)
      else $error("unprivileged access did not fault");

endmodule : exception_fp_context_state
